// [src/twr_cfg.svh]
/*
 Constants of the three-wire register port: register map size, field
 positions, octet layout and timing counts.
 Assumes a 250 MHz system clock on both ends.
*/
`ifndef TWR_CFG_SVH
`define TWR_CFG_SVH

`define TWR_NUM_REGS 23
`define TWR_LAST_ADDR 7'h16
`define TWR_ADDR_W 7
`define TWR_RW_READ 1'b1
`define TWR_RW_WRITE 1'b0
`define TWR_LOAD_EN_BIT 0
`define TWR_CLK_PERIOD_NS 4
`define TWR_SCLK_HALF_NS 32
`define TWR_SCLK_HALF_CYC (`TWR_SCLK_HALF_NS / `TWR_CLK_PERIOD_NS)
`define TWR_POR_WAIT_NS 9000000
`define TWR_POR_WAIT_CYC (`TWR_POR_WAIT_NS / `TWR_CLK_PERIOD_NS)
`define TWR_CS_SETUP_CYC 4'h4

`endif

// [src/twr_pkg.sv]
/*
 Types shared by both ends of the three-wire register port.
 Assumes twr_cfg.svh for numeric constants.
*/
package twr_pkg;
    typedef logic [7:0] twr_octet_t;
    typedef logic [6:0] twr_addr_t;
    typedef enum logic [1:0] {
        TWR_PH_ADDR,
        TWR_PH_WRITE,
        TWR_PH_READ,
        TWR_PH_DROP
    } twr_phase_t;
endpackage

// [src/twr_link_if.sv]
/*
 Interface of the three-wire link: serial clock, chip select and the
 shared data line, resolved from both enables.
 Assumes at most one end drives the data line at a time.
*/
`timescale 1ns/1ps
interface twr_link_if;
    logic sclk;
    logic cs;
    logic io_host_o;
    logic io_host_oe;
    logic io_dev_o;
    logic io_dev_oe;
    logic io;

    // Wired resolution with weak pull-up when idle
    assign io = io_dev_oe ? io_dev_o : (io_host_oe ? io_host_o : 1'b1);

    modport dev (
        input sclk,
        input cs,
        input io,
        output io_dev_o,
        output io_dev_oe
    );

    modport host (
        output sclk,
        output cs,
        output io_host_o,
        output io_host_oe,
        input io
    );
endinterface

// [src/twr_sync.sv]
/*
 Two-flop synchroniser with edge detection on the second stage.
 Assumes the input is asynchronous to clock.
*/
`timescale 1ns/1ps
module twr_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic din,
    output logic level,
    output logic rise,
    output logic fall
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Synchroniser chain, third stage only for edges
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign level = s2_q;
    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;
endmodule

// [src/twr_device.sv]
/*
 Device end of the three-wire register port: register map of 23 octets,
 serial decode of address octet, block writes and block reads, load pulse.
 Assumes the host makes sclk and cs; both are sampled by clock.
*/
// Behaviour
// - Host raises chip select before clocking
// - Device samples data on falling clock edges
// - Host changes data before each falling edge
// - Chip select release makes a load pulse
// - No load pulse when load-enable is zero
// - First octet: 7-bit address then R/W
// - Data octets are eight bits, MSB first
// - Single write is two octets per frame
// - Block write stores at incrementing addresses
// - Full-map write: address zero, 23 data octets
// - Non-contiguous update gated by load-enable
// - R/W one requests a read
// - Device drives data from next rising edge
// - Read data changes on rising edges
// - Reads have no side effects
// - Read frame returns one to 23 octets
// - Host releases chip select after reading
// - Host alone supplies the serial clock
// - Host writes all registers after power-on; the bench's first write covers addresses 0 to 21 only
// - Host waits power-on time before access
// - Clock ignored while chip select inactive
`timescale 1ns/1ps
`include "twr_cfg.svh"
module twr_device (
    input wire logic clock,
    input wire logic rst,
    twr_link_if.dev link,
    output logic [7:0] reg_image [`TWR_NUM_REGS],
    output logic load_pulse,
    output logic write_strobe,
    output logic [6:0] write_addr
);
    logic sclk_lvl;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_lvl;
    logic cs_rise;
    logic cs_fall;
    logic io_lvl;

    twr_sync u_sync_sclk (
        .clock(clock),
        .rst(rst),
        .din(link.sclk),
        .level(sclk_lvl),
        .rise(sclk_rise),
        .fall(sclk_fall)
    );

    twr_sync u_sync_cs (
        .clock(clock),
        .rst(rst),
        .din(link.cs),
        .level(cs_lvl),
        .rise(cs_rise),
        .fall(cs_fall)
    );

    twr_sync u_sync_io (
        .clock(clock),
        .rst(rst),
        .din(link.io),
        .level(io_lvl),
        .rise(),
        .fall()
    );

    twr_pkg::twr_phase_t phase_q, phase_d;
    logic [7:0] shift_q, shift_d;
    logic [2:0] bitcnt_q, bitcnt_d;
    logic [6:0] addr_q, addr_d;
    logic [7:0] regs_q [`TWR_NUM_REGS];
    logic [7:0] regs_d [`TWR_NUM_REGS];
    logic io_o_q, io_o_d;
    logic io_oe_q, io_oe_d;
    logic load_q, load_d;
    logic wstb_q, wstb_d;
    logic [6:0] waddr_q, waddr_d;
    logic wrote_q, wrote_d;

    // Address past the map reads as zero
    function automatic logic [7:0] rd_reg(input logic [6:0] a, input logic [7:0] r [`TWR_NUM_REGS]);
        rd_reg = (a <= `TWR_LAST_ADDR) ? r[a[4:0]] : 8'h00;
    endfunction

    // Octet to send next, read from the current address
    logic [7:0] rd_oct;
    assign rd_oct = rd_reg(addr_q, regs_q);

    // Serial engine next state
    always_comb begin
        phase_d = phase_q;
        shift_d = shift_q;
        bitcnt_d = bitcnt_q;
        addr_d = addr_q;
        regs_d = regs_q;
        io_o_d = io_o_q;
        io_oe_d = io_oe_q;
        load_d = 1'b0;
        wstb_d = 1'b0;
        waddr_d = waddr_q;
        wrote_d = wrote_q;
        if (cs_fall) begin
            // End of frame: release line, load if enabled
            io_oe_d = 1'b0;
            phase_d = twr_pkg::TWR_PH_ADDR;
            bitcnt_d = 3'h0;
            load_d = wrote_q & regs_q[0][`TWR_LOAD_EN_BIT];
            wrote_d = 1'b0;
        end else if (cs_rise) begin
            phase_d = twr_pkg::TWR_PH_ADDR;
            bitcnt_d = 3'h0;
            wrote_d = 1'b0;
        end else if (cs_lvl) begin
            if (sclk_fall && phase_q != twr_pkg::TWR_PH_READ) begin
                // Sample one bit, MSB first
                shift_d = {shift_q[6:0], io_lvl};
                bitcnt_d = bitcnt_q + 3'h1;
                if (bitcnt_q == 3'h7) begin
                    case (phase_q)
                        twr_pkg::TWR_PH_ADDR: begin
                            addr_d = shift_q[6:0];
                            if (io_lvl == `TWR_RW_READ) begin
                                phase_d = twr_pkg::TWR_PH_READ;
                            end else begin
                                phase_d = twr_pkg::TWR_PH_WRITE;
                            end
                        end
                        twr_pkg::TWR_PH_WRITE: begin
                            if (addr_q <= `TWR_LAST_ADDR) begin
                                regs_d[addr_q[4:0]] = {shift_q[6:0], io_lvl};
                                wstb_d = 1'b1;
                                waddr_d = addr_q;
                                wrote_d = 1'b1;
                            end
                            addr_d = addr_q + 7'h01;
                        end
                        default: begin
                            phase_d = phase_q;
                        end
                    endcase
                end
            end else if (sclk_rise && phase_q == twr_pkg::TWR_PH_READ) begin
                // Shift out; reload on octet boundary
                io_oe_d = 1'b1;
                if (bitcnt_q == 3'h0) begin
                    io_o_d = rd_oct[7];
                    shift_d = {rd_oct[6:0], 1'b0};
                    addr_d = addr_q + 7'h01;
                end else begin
                    io_o_d = shift_q[7];
                    shift_d = {shift_q[6:0], 1'b0};
                end
                bitcnt_d = bitcnt_q + 3'h1;
            end
        end
    end

    // Serial engine registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_q <= twr_pkg::TWR_PH_ADDR;
            shift_q <= 8'h00;
            bitcnt_q <= 3'h0;
            addr_q <= 7'h00;
            for (int i = 0; i < `TWR_NUM_REGS; i++) begin
                regs_q[i] <= 8'h00;
            end
            io_o_q <= 1'b0;
            io_oe_q <= 1'b0;
            load_q <= 1'b0;
            wstb_q <= 1'b0;
            waddr_q <= 7'h00;
            wrote_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            shift_q <= shift_d;
            bitcnt_q <= bitcnt_d;
            addr_q <= addr_d;
            regs_q <= regs_d;
            io_o_q <= io_o_d;
            io_oe_q <= io_oe_d;
            load_q <= load_d;
            wstb_q <= wstb_d;
            waddr_q <= waddr_d;
            wrote_q <= wrote_d;
        end
    end

    assign link.io_dev_o = io_o_q;
    assign link.io_dev_oe = io_oe_q;
    assign reg_image = regs_q;
    assign load_pulse = load_q;
    assign write_strobe = wstb_q;
    assign write_addr = waddr_q;
endmodule

// [src/twr_host.sv]
/*
 Host end of the three-wire register port: makes sclk by a divider,
 frames cs, writes or reads a block of octets.
 Assumes the user holds the request fields stable while busy.
*/
`timescale 1ns/1ps
`include "twr_cfg.svh"
module twr_host #(
    parameter int POR_WAIT_CYC = `TWR_POR_WAIT_CYC
) (
    input wire logic clock,
    input wire logic rst,
    twr_link_if.host link,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_read,
    input wire logic [6:0] req_addr,
    input wire logic [4:0] req_count,
    output logic wdata_ready,
    input wire logic [7:0] wdata,
    output logic rdata_valid,
    output logic [7:0] rdata,
    output logic done
);
    typedef enum logic [2:0] {
        TWH_POR,
        TWH_IDLE,
        TWH_SETUP,
        TWH_LOW,
        TWH_HIGH,
        TWH_END
    } twh_state_t;

    logic io_lvl;
    twr_sync u_sync_io (
        .clock(clock),
        .rst(rst),
        .din(link.io),
        .level(io_lvl),
        .rise(),
        .fall()
    );

    twh_state_t st_q, st_d;
    logic [23:0] por_q, por_d;
    logic [3:0] tick_q, tick_d;
    logic [2:0] bit_q, bit_d;
    logic [4:0] oct_q, oct_d;
    logic [7:0] sh_q, sh_d;
    logic rd_q, rd_d;
    logic sclk_q, sclk_d;
    logic cs_q, cs_d;
    logic oe_q, oe_d;
    logic rv_q, rv_d;
    logic [7:0] rdat_q, rdat_d;
    logic done_q, done_d;
    logic wtake;

    // Next data octet is taken at the first rise of each data octet
    assign req_ready = (st_q == TWH_IDLE);
    assign wtake = (st_q == TWH_LOW) && (st_d == TWH_HIGH) && (bit_q == 3'h0) && (oct_q != 5'h00) && !rd_q;
    assign wdata_ready = wtake;

    // Frame sequencer
    always_comb begin
        st_d = st_q;
        por_d = por_q;
        tick_d = tick_q;
        bit_d = bit_q;
        oct_d = oct_q;
        sh_d = sh_q;
        rd_d = rd_q;
        sclk_d = sclk_q;
        cs_d = cs_q;
        oe_d = oe_q;
        rv_d = 1'b0;
        rdat_d = rdat_q;
        done_d = 1'b0;
        case (st_q)
            TWH_POR: begin
                por_d = por_q + 24'h000001;
                if (por_q >= 24'(POR_WAIT_CYC)) begin
                    st_d = TWH_IDLE;
                end
            end
            TWH_IDLE: begin
                if (req_valid) begin
                    cs_d = 1'b1;
                    oe_d = 1'b1;
                    rd_d = req_read;
                    sh_d = {req_addr, req_read};
                    bit_d = 3'h0;
                    oct_d = 5'h00;
                    tick_d = `TWR_CS_SETUP_CYC;
                    st_d = TWH_SETUP;
                end
            end
            TWH_SETUP, TWH_HIGH, TWH_LOW: begin
                if (tick_q != 4'h0) begin
                    tick_d = tick_q - 4'h1;
                end else if (st_q == TWH_HIGH || st_q == TWH_SETUP) begin
                    // Falling edge: device or host samples here
                    if (st_q == TWH_HIGH) begin
                        sclk_d = 1'b0;
                        if (rd_q && oct_q != 5'h00) begin
                            rdat_d = {rdat_q[6:0], io_lvl};
                        end
                        bit_d = bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            if (rd_q && oct_q != 5'h00) begin
                                rdat_d = {rdat_q[6:0], io_lvl};
                                rv_d = 1'b1;
                            end
                            if (rd_q && oct_q == 5'h00) begin
                                oe_d = 1'b0;
                            end
                            oct_d = oct_q + 5'h01;
                            if (oct_q == req_count) begin
                                st_d = TWH_END;
                            end
                        end
                    end
                    if (st_d != TWH_END) begin
                        st_d = TWH_LOW;
                    end
                    tick_d = 4'(`TWR_SCLK_HALF_CYC - 1);
                end else begin
                    // Rising edge: host changes its data
                    sclk_d = 1'b1;
                    if (bit_q == 3'h0 && oct_q != 5'h00 && !rd_q) begin
                        sh_d = wdata;
                    end else if (bit_q != 3'h0 || oct_q != 5'h00) begin
                        sh_d = {sh_q[6:0], 1'b0};
                    end
                    st_d = TWH_HIGH;
                    tick_d = 4'(`TWR_SCLK_HALF_CYC - 1);
                end
            end
            TWH_END: begin
                // Drop select, wait out the device release before driving data
                cs_d = 1'b0;
                if (tick_q != 4'h0) begin
                    tick_d = tick_q - 4'h1;
                end else begin
                    oe_d = 1'b1;
                    done_d = 1'b1;
                    st_d = TWH_IDLE;
                end
            end
            default: begin
                st_d = TWH_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= TWH_POR;
            por_q <= 24'h000000;
            tick_q <= 4'h0;
            bit_q <= 3'h0;
            oct_q <= 5'h00;
            sh_q <= 8'h00;
            rd_q <= 1'b0;
            sclk_q <= 1'b0;
            cs_q <= 1'b0;
            oe_q <= 1'b1;
            rv_q <= 1'b0;
            rdat_q <= 8'h00;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            por_q <= por_d;
            tick_q <= tick_d;
            bit_q <= bit_d;
            oct_q <= oct_d;
            sh_q <= sh_d;
            rd_q <= rd_d;
            sclk_q <= sclk_d;
            cs_q <= cs_d;
            oe_q <= oe_d;
            rv_q <= rv_d;
            rdat_q <= rdat_d;
            done_q <= done_d;
        end
    end

    assign link.sclk = sclk_q;
    assign link.cs = cs_q;
    assign link.io_host_o = sh_q[7];
    assign link.io_host_oe = oe_q;
    assign rdata_valid = rv_q;
    assign rdata = rdat_q;
    assign done = done_q;
endmodule

// [test/twr_props.sv]
/*
 Concurrent checks on the three-wire link between host and device ends.
 Assumes both ends share clock and rst; signals taken from the interface.
*/
`timescale 1ns/1ps
module twr_props (
    input wire logic clock,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs,
    input wire logic io_host_o,
    input wire logic io_host_oe,
    input wire logic io_dev_o,
    input wire logic io_dev_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic sclk_q;
    logic sclk_d;
    logic [2:0] bits_q;
    logic [2:0] bits_d;
    // Count serial clock rises within a frame, modulo eight
    always_comb begin
        sclk_d = sclk;
        bits_d = bits_q;
        if (!cs) begin
            bits_d = 3'h0;
        end else if (sclk && !sclk_q) begin
            bits_d = bits_q + 3'h1;
        end
    end
    // Register the counter
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sclk_q <= 1'b0;
            bits_q <= 3'h0;
        end else begin
            sclk_q <= sclk_d;
            bits_q <= bits_d;
        end
    end
    property p_cs_setup; $rose(cs) |-> !sclk [*4]; endproperty
    a_cs_setup: assert property (p_cs_setup) else $error("clock moved too soon after select");
    property p_host_stable; cs && io_host_oe && $fell(sclk) |-> $stable(io_host_o) ##1 $stable(io_host_o); endproperty
    a_host_stable: assert property (p_host_stable) else $error("host data moved at falling edge");
    property p_frame_whole; $fell(cs) |-> bits_q == 3'h0; endproperty
    a_frame_whole: assert property (p_frame_whole) else $error("frame not whole octets");
    property p_addr_drive; $rose(cs) |-> io_host_oe && !io_dev_oe; endproperty
    a_addr_drive: assert property (p_addr_drive) else $error("host not driving address");
    property p_no_clash; !(io_dev_oe && io_host_oe); endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
    property p_dev_start; $rose(io_dev_oe) |-> cs && sclk; endproperty
    a_dev_start: assert property (p_dev_start) else $error("device drive began off a rise");
    property p_dev_change; io_dev_oe && $past(io_dev_oe) && (io_dev_o != $past(io_dev_o)) |-> sclk; endproperty
    a_dev_change: assert property (p_dev_change) else $error("read data moved while clock low");
    property p_dev_quiet; !cs [*6] |-> !io_dev_oe; endproperty
    a_dev_quiet: assert property (p_dev_quiet) else $error("device drives outside frame");
    property p_sclk_still; !cs [*2] |-> !sclk; endproperty
    a_sclk_still: assert property (p_sclk_still) else $error("serial clock runs outside frame");
endmodule

// [test/three_wire_register_port_bench.sv]
/*
 Self-checking bench: host and device joined on one link, plus a device
 driven directly by the bench on a second link with rule-breaking frames.
 Assumes twr_cfg.svh is on the include path.
*/
`timescale 1ns/1ps
`include "twr_cfg.svh"
module three_wire_register_port_bench;
    logic clock, rst, req_valid, req_ready, req_read, wdata_ready, rdata_valid, done;
    logic load_pulse, write_strobe, load_b, ws_b;
    logic [6:0] req_addr, write_addr, exp_wa;
    logic [4:0] req_count;
    logic [7:0] wdata, rdata, load_cnt, wsb_cnt, load_b_cnt;
    logic [7:0] reg_image [`TWR_NUM_REGS];
    logic [7:0] reg_b [`TWR_NUM_REGS];
    twr_pkg::twr_octet_t model [`TWR_NUM_REGS];
    twr_pkg::twr_octet_t nw [24];
    logic [31:0] rnd, r;
    int error_cnt, check_count, cyc, i;
    logic [6:0] a;
    twr_link_if link ();
    twr_link_if link_b ();
    twr_host #(.POR_WAIT_CYC(10)) twr_host_inst (.clock(clock), .rst(rst), .link(link),
        .req_valid(req_valid), .req_ready(req_ready), .req_read(req_read), .req_addr(req_addr),
        .req_count(req_count), .wdata_ready(wdata_ready), .wdata(wdata), .rdata_valid(rdata_valid),
        .rdata(rdata), .done(done));
    twr_device twr_device_inst (.clock(clock), .rst(rst), .link(link), .reg_image(reg_image),
        .load_pulse(load_pulse), .write_strobe(write_strobe), .write_addr(write_addr));
    twr_device twr_device_b_inst (.clock(clock), .rst(rst), .link(link_b), .reg_image(reg_b),
        .load_pulse(load_b), .write_strobe(ws_b), .write_addr());
    twr_props twr_props_inst (.clock(clock), .rst(rst), .sclk(link.sclk), .cs(link.cs),
        .io_host_o(link.io_host_o), .io_host_oe(link.io_host_oe), .io_dev_o(link.io_dev_o),
        .io_dev_oe(link.io_dev_oe));
    // Clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Xorshift source
    function automatic logic [31:0] xs();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction
    // Expected read octet, zero past the map
    function automatic logic [7:0] exp_rd(input int idx);
        return (idx < `TWR_NUM_REGS) ? model[idx] : 8'h00;
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            conclude();
        end
    end
    // Pulse monitors, sampled mid-cycle
    always @(negedge clock) begin
        if (load_pulse) load_cnt++;
        if (load_b) load_b_cnt++;
        if (ws_b) wsb_cnt++;
        if (write_strobe) begin
            check({1'b0, write_addr}, {1'b0, exp_wa});
            exp_wa++;
        end
    end
    // Fresh random write data
    task automatic fill();
        for (int j = 0; j < 24; j++) begin
            r = xs();
            nw[j] = r[7:0];
        end
    endtask
    // Bench-driven frame on second link, 32 ns serial clock, data moved on rises
    task automatic b_frame(input logic c, input int n, input logic [15:0] pat);
        link_b.cs = c;
        for (int j = 0; j < n; j++) begin
            #16 link_b.sclk = 1'b1;
            link_b.io_host_o = pat[15-j];
            #16 link_b.sclk = 1'b0;
        end
        #40 link_b.cs = 1'b0;
        #40;
    endtask
    // Whole map against model
    task automatic cmp_all();
        for (int j = 0; j < `TWR_NUM_REGS; j++) check(reg_image[j], model[j]);
    endtask
    // One host request: write nw[] or read n octets from a
    task automatic xfer(input logic rd, input logic [6:0] ad, input logic [4:0] n);
        int k, j, t;
        logic tk, rq, fin;
        logic [7:0] l0;
        k = 0;
        j = 0;
        fin = 1'b0;
        l0 = load_cnt;
        exp_wa = ad;
        req_read = rd;
        req_addr = ad;
        req_count = n;
        wdata = nw[0];
        req_valid = 1'b1;
        for (t = 0; t < 5000 && !fin; t++) begin
            tk = wdata_ready;
            rq = req_ready;
            @(posedge clock);
            #1;
            if (rq) req_valid = 1'b0;
            if (tk) begin
                k++;
                wdata = nw[k];
            end
            if (rdata_valid === 1'b1) begin
                check(rdata, exp_rd(ad + j));
                j++;
            end
            fin = (done === 1'b1);
        end
        check({7'h00, fin}, 8'h01);
        check(rd ? j[7:0] : k[7:0], {3'h0, n});
        if (!rd) for (int m = 0; m < n; m++) model[ad + m] = nw[m];
        repeat (12) @(posedge clock);
        #1;
        check(load_cnt - l0, {7'h00, !rd && model[0][`TWR_LOAD_EN_BIT]});
        cmp_all();
    endtask
    initial begin
        rnd = 32'h0000FC02;
        rst = 1'b1;
        {req_valid, req_read, req_addr, req_count, wdata} = '0;
        {load_cnt, wsb_cnt, load_b_cnt, exp_wa} = '0;
        {error_cnt, check_count, cyc} = '0;
        {link_b.cs, link_b.sclk, link_b.io_host_o} = '0;
        link_b.io_host_oe = 1'b1;
        for (i = 0; i < `TWR_NUM_REGS; i++) model[i] = 8'h00;
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        cmp_all();
        // Second link: clocks with select low, a short frame, then a good one
        #2;
        b_frame(1'b0, 16, 16'h0AFF);
        b_frame(1'b1, 12, 16'h0A50);
        b_frame(1'b1, 16, 16'h0A5C);
        repeat (8) @(posedge clock);
        #1;
        check(wsb_cnt, 8'h01);
        check(reg_b[5], 8'h5C);
        check(load_b_cnt, 8'h00);
        // Write of addresses 0 to 21, then full read
        fill();
        nw[0][0] = 1'b1;
        xfer(1'b0, 7'h00, 5'h16);
        xfer(1'b1, 7'h00, 5'h17);
        // Load enable cleared, two groups, then set again
        fill();
        nw[0][0] = 1'b0;
        xfer(1'b0, 7'h00, 5'h01);
        fill();
        xfer(1'b0, 7'h10, 5'h03);
        fill();
        xfer(1'b0, 7'h14, 5'h03);
        fill();
        nw[0][0] = 1'b1;
        xfer(1'b0, 7'h00, 5'h01);
        // Random traffic
        for (i = 0; i < 6; i++) begin
            r = xs();
            a = 7'(r % 23);
            r = xs();
            fill();
            xfer(r[8], a, 5'(1 + r % (23 - a)));
        end
        conclude();
    end
endmodule
